// file: design/sps_pkg.sv
package sps_pkg;

  // Register indices; byte address is four times the index
  localparam logic [1:0] SPS_IDX_CONTROL = 2'h0;
  localparam logic [1:0] SPS_IDX_IRQ = 2'h1;
  localparam logic [1:0] SPS_IDX_STATUS = 2'h2;
  localparam logic [1:0] SPS_IDX_DATA = 2'h3;
  localparam logic [7:0] SPS_RST_CONTROL = 8'h00;
  localparam logic [7:0] SPS_RST_IRQ = 8'h00;
  localparam logic [7:0] SPS_RST_DATA = 8'h00;

  // Control and status register field positions
  localparam int SPS_B_DOUBLE = 7;
  localparam int SPS_B_ENABLE = 6;
  localparam int SPS_B_ORDER = 5;
  localparam int SPS_B_MASTER = 4;
  localparam int SPS_B_MODE_HI = 3;
  localparam int SPS_B_MODE_LO = 2;
  localparam int SPS_B_DIV_HI = 1;
  localparam int SPS_B_DIV_LO = 0;
  localparam int SPS_B_DONE = 7;
  localparam int SPS_B_WCOL = 6;

  localparam logic [1:0] SPS_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] SPS_HTRANS_SEQ = 2'h3;
  localparam logic [2:0] SPS_BIT_LAST = 3'h7;
  localparam logic [6:0] SPS_HALF_ONE = 7'h01;

  typedef struct packed {
    logic double_speed;
    logic enable;
    logic bit_order_select;
    logic master;
    logic [1:0] mode;
    logic [1:0] divider;
  } sps_ctrl_t;

  typedef enum logic [1:0] {
    SPS_IDLE = 2'b00,
    SPS_LEAD = 2'b01,
    SPS_TRAIL = 2'b11
  } sps_state_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } sps_pins_t;

endpackage : sps_pkg

// file: design/sps_top.sv
// Operation
// - Enable forces pin directions by role
// - Data write starts eight-bit master shift
// - Completed byte kept in receive buffer
// - Low select input demotes master while SS_DIR_OUT is low, flags
// - Idle slave tristates output, ignores clock
// - Selected slave shifts, flags each byte
// - Deselect resets shifter and bit counter
// - Modes 00/01 idle low timing
// - Modes 10/11 idle high timing
// - Bit order select picks lsb first
// - Normal speed dividers 4/16/64/128
// - Double speed dividers 2/8/32/64
// - No serial operation unless enabled
// - Nonzero level requests interrupt on done
// - Done clears by vector or status-data
// - Data write mid-transfer sets collision flag
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/10ps
module sps_top
  import sps_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic SCK_IN,
  output logic SCK_OUT,
  output logic SCK_OE,
  input wire logic MOSI_IN,
  output logic MOSI_OUT,
  output logic MOSI_OE,
  input wire logic MISO_IN,
  output logic MISO_OUT,
  output logic MISO_OE,
  input wire logic SS_N_IN,
  input wire logic SS_DIR_OUT,
  input wire logic MOSI_DIR_OUT,
  input wire logic SCK_DIR_OUT,
  input wire logic MISO_DIR_OUT,
  input wire logic IRQ_VECTOR_ACK,
  output logic [1:0] IRQ_REQ
);

  typedef struct packed {
    sps_ctrl_t ctrl;
    logic [1:0] interrupt_level;
    logic done;
    logic write_collision_flag;
    logic status_seen;
    logic [7:0] tx_byte;
    logic [7:0] shift;
    logic [7:0] rx_buf;
    logic [2:0] bits;
    logic [6:0] div_cnt;
    sps_state_t st;
    logic sck_q;
    logic out_bit;
    logic sck_seen;
    logic ss_seen;
    logic ph_wr;
    logic ph_rd;
    logic [1:0] ph_idx;
    logic [31:0] rdata;
  } sps_state_s_t;

  sps_state_s_t r_q;
  sps_state_s_t r_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [6:0] sps_half(input logic dbl, input logic [1:0] code);
    logic [7:0] full;
    full = 8'h00;
    unique case ({dbl, code})
      3'b000: full = 8'h04;
      3'b001: full = 8'h10;
      3'b010: full = 8'h40;
      3'b011: full = 8'h80;
      3'b100: full = 8'h02;
      3'b101: full = 8'h08;
      3'b110: full = 8'h20;
      3'b111: full = 8'h40;
    endcase
    sps_half = full[7:1];
  endfunction : sps_half

  function automatic logic sps_first(input logic [7:0] b, input logic lsb);
    sps_first = lsb ? b[0] : b[7];
  endfunction : sps_first

  function automatic logic [7:0] sps_shift(input logic [7:0] b, input logic lsb, input logic in_bit);
    sps_shift = lsb ? {in_bit, b[7:1]} : {b[6:0], in_bit};
  endfunction : sps_shift

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  logic enable;
  logic is_master;
  logic cpha;
  logic cpol;
  logic ss_in_role;
  logic slave_sel;
  logic sck_rise;
  logic sck_fall;
  logic lead_edge;
  logic trail_edge;
  logic sample_edge;
  logic setup_edge;
  logic busy;
  logic data_wr;
  logic data_acc;
  logic in_bit;
  logic [7:0] nxt;

  always_comb
  begin
    r_d = r_q;
    enable = r_q.ctrl.enable;
    is_master = r_q.ctrl.master;
    cpol = r_q.ctrl.mode[1];
    cpha = r_q.ctrl.mode[0];
    ss_in_role = !is_master || !SS_DIR_OUT;
    slave_sel = enable && !is_master && !SS_N_IN;
    sck_rise = SCK_IN && !r_q.sck_seen;
    sck_fall = !SCK_IN && r_q.sck_seen;
    lead_edge = cpol ? sck_fall : sck_rise;
    trail_edge = cpol ? sck_rise : sck_fall;
    sample_edge = cpha ? trail_edge : lead_edge;
    setup_edge = cpha ? lead_edge : trail_edge;
    busy = (is_master && r_q.st != SPS_IDLE) || (slave_sel && r_q.bits != 3'h0);
    data_wr = r_q.ph_wr && r_q.ph_idx == SPS_IDX_DATA;
    data_acc = (r_q.ph_wr || r_q.ph_rd) && r_q.ph_idx == SPS_IDX_DATA;
    in_bit = is_master ? MISO_IN : MOSI_IN;
    nxt = r_q.shift;
    r_d.sck_seen = SCK_IN;
    r_d.ss_seen = SS_N_IN;

    // Bus data phase
    if (r_q.ph_wr)
    begin
      unique case (r_q.ph_idx)
        SPS_IDX_CONTROL: r_d.ctrl = sps_ctrl_t'(HWDATA[7:0]);
        SPS_IDX_IRQ: r_d.interrupt_level = HWDATA[1:0];
        SPS_IDX_STATUS: ;
        SPS_IDX_DATA:
        begin
          if (busy)
            r_d.write_collision_flag = 1'b1;
          else
          begin
            r_d.tx_byte = HWDATA[7:0];
            r_d.shift = HWDATA[7:0];
            nxt = HWDATA[7:0];
          end
        end
      endcase
    end
    if (r_q.ph_rd && r_q.ph_idx == SPS_IDX_STATUS)
      r_d.status_seen = r_q.done || r_q.write_collision_flag;
    if (data_acc && r_q.status_seen)
    begin
      r_d.done = 1'b0;
      r_d.write_collision_flag = data_wr && busy;
      r_d.status_seen = 1'b0;
    end
    if (IRQ_VECTOR_ACK)
      r_d.done = 1'b0;

    // Serial engine
    if (!enable)
    begin
      r_d.st = SPS_IDLE;
      r_d.bits = 3'h0;
      r_d.sck_q = cpol;
    end
    else if (is_master)
    begin
      if (ss_in_role && !SS_N_IN)
      begin
        r_d.ctrl.master = 1'b0;
        r_d.done = 1'b1;
        r_d.st = SPS_IDLE;
        r_d.bits = 3'h0;
      end
      else
      begin
        unique case (r_q.st)
          SPS_IDLE:
          begin
            r_d.sck_q = cpol;
            r_d.out_bit = sps_first(nxt, r_q.ctrl.bit_order_select);
            if (data_wr && !busy)
            begin
              r_d.st = SPS_LEAD;
              r_d.div_cnt = sps_half(r_q.ctrl.double_speed, r_q.ctrl.divider);
              r_d.bits = 3'h0;
            end
          end
          SPS_LEAD, SPS_TRAIL:
          begin
            if (r_q.div_cnt == SPS_HALF_ONE)
            begin
              r_d.div_cnt = sps_half(r_q.ctrl.double_speed, r_q.ctrl.divider);
              r_d.sck_q = !r_q.sck_q;
              if (r_q.st == SPS_LEAD)
              begin
                r_d.st = SPS_TRAIL;
                if (cpha)
                  r_d.out_bit = sps_first(r_q.shift, r_q.ctrl.bit_order_select);
                else
                  r_d.shift = sps_shift(r_q.shift, r_q.ctrl.bit_order_select, in_bit);
              end
              else
              begin
                if (cpha)
                  r_d.shift = sps_shift(r_q.shift, r_q.ctrl.bit_order_select, in_bit);
                r_d.bits = r_q.bits + 3'h1;
                if (r_q.bits == SPS_BIT_LAST)
                begin
                  r_d.st = SPS_IDLE;
                  r_d.done = 1'b1;
                  r_d.rx_buf = cpha ? sps_shift(r_q.shift, r_q.ctrl.bit_order_select, in_bit)
                                    : r_q.shift;
                end
                else
                begin
                  r_d.st = SPS_LEAD;
                  if (!cpha)
                    r_d.out_bit = sps_first(r_q.shift, r_q.ctrl.bit_order_select);
                end
              end
            end
            else
              r_d.div_cnt = r_q.div_cnt - SPS_HALF_ONE;
          end
        endcase
      end
    end
    else
    begin
      r_d.st = SPS_IDLE;
      r_d.sck_q = cpol;
      if (SS_N_IN)
      begin
        r_d.bits = 3'h0;
        r_d.shift = r_d.tx_byte;
        r_d.out_bit = sps_first(r_d.tx_byte, r_q.ctrl.bit_order_select);
      end
      else
      begin
        if (r_q.ss_seen || (data_wr && !busy))
          r_d.out_bit = sps_first(nxt, r_q.ctrl.bit_order_select);
        if (sample_edge)
        begin
          r_d.shift = sps_shift(r_q.shift, r_q.ctrl.bit_order_select, MOSI_IN);
          r_d.bits = r_q.bits + 3'h1;
          if (r_q.bits == SPS_BIT_LAST)
          begin
            r_d.done = 1'b1;
            r_d.rx_buf = sps_shift(r_q.shift, r_q.ctrl.bit_order_select, MOSI_IN);
          end
        end
        if (setup_edge && !(cpha == 1'b0 && r_q.bits == 3'h0 && !r_q.ss_seen))
          r_d.out_bit = sps_first(r_q.shift, r_q.ctrl.bit_order_select);
      end
    end

    // Bus address phase
    r_d.ph_wr = HSEL && HREADY && HTRANS[1] && HWRITE;
    r_d.ph_rd = HSEL && HREADY && HTRANS[1] && !HWRITE;
    r_d.ph_idx = HADDR[3:2];
    r_d.rdata = 32'h0000_0000;
    if (HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR[31:4] == 28'h000_0000)
    begin
      unique case (HADDR[3:2])
        SPS_IDX_CONTROL: r_d.rdata = {24'h00_0000, r_q.ctrl};
        SPS_IDX_IRQ: r_d.rdata = {30'h0000_0000, r_q.interrupt_level};
        SPS_IDX_STATUS: r_d.rdata = {24'h00_0000, r_q.done, r_q.write_collision_flag, 6'h00};
        SPS_IDX_DATA: r_d.rdata = {24'h00_0000, r_q.rx_buf};
      endcase
    end
    if (HADDR[31:4] != 28'h000_0000)
    begin
      r_d.ph_wr = 1'b0;
      r_d.ph_rd = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      r_q <= '0;
      r_q.ctrl <= sps_ctrl_t'(SPS_RST_CONTROL);
      r_q.interrupt_level <= SPS_RST_IRQ[1:0];
      r_q.tx_byte <= SPS_RST_DATA;
      r_q.shift <= SPS_RST_DATA;
      r_q.rx_buf <= SPS_RST_DATA;
      r_q.st <= SPS_IDLE;
      r_q.sck_seen <= 1'b0;
      r_q.ss_seen <= 1'b1;
    end
    else
      r_q <= r_d;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_comb
  begin
    HRDATA = r_q.rdata;
    HREADYOUT = 1'b1;
    HRESP = 1'b0;
    IRQ_REQ = r_q.done ? r_q.interrupt_level : 2'h0;
    SCK_OUT = r_q.sck_q;
    MOSI_OUT = r_q.out_bit;
    MISO_OUT = r_q.out_bit;
    if (r_q.ctrl.enable && r_q.ctrl.master)
    begin
      SCK_OE = SCK_DIR_OUT;
      MOSI_OE = MOSI_DIR_OUT;
      MISO_OE = 1'b0;
    end
    else if (r_q.ctrl.enable)
    begin
      SCK_OE = 1'b0;
      MOSI_OE = 1'b0;
      MISO_OE = MISO_DIR_OUT && !SS_N_IN;
    end
    else
    begin
      SCK_OE = SCK_DIR_OUT;
      MOSI_OE = MOSI_DIR_OUT;
      MISO_OE = MISO_DIR_OUT;
    end
  end

endmodule : sps_top

// file: test/sps_assertions.sv
`timescale 1ns/10ps
module sps_assertions (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic HSEL,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic SCK_IN,
  input wire logic SS_N_IN,
  input wire logic SCK_OUT,
  input wire logic SCK_OE,
  input wire logic MOSI_OE,
  input wire logic MISO_OE,
  input wire logic SCK_DIR_OUT,
  input wire logic MOSI_DIR_OUT,
  input wire logic MISO_DIR_OUT,
  input wire logic IRQ_VECTOR_ACK,
  input wire logic [1:0] IRQ_REQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // Acknowledge while no serial edge or select event can complete a byte
  sequence s_ack;
    IRQ_VECTOR_ACK && SS_N_IN && $stable(SCK_IN) ##1 $stable(SCK_OUT);
  endsequence
  sequence s_quiet;
    (!HSEL && !IRQ_VECTOR_ACK)[*3] ##0 IRQ_REQ != 2'h0;
  endsequence
  a_ready_high: assert property (HREADYOUT) else $error("hreadyout low");
  a_resp_okay: assert property (!HRESP) else $error("error response");
  a_rdata_upper: assert property (HRDATA[31:8] == 24'h00_0000) else $error("upper bits set");
  a_miso_dir: assert property (MISO_OE |-> MISO_DIR_OUT) else $error("miso driven");
  a_mosi_dir: assert property (MOSI_OE |-> MOSI_DIR_OUT) else $error("mosi driven");
  a_sck_dir: assert property (SCK_OE |-> SCK_DIR_OUT) else $error("sck driven");
  a_ack_clears: assert property (s_ack |-> IRQ_REQ == 2'h0) else $error("ack kept flag");
  a_irq_holds: assert property (s_quiet |=> $stable(IRQ_REQ)) else $error("request moved");
endmodule : sps_assertions

bind sps_top sps_assertions u_sps_assertions (.CLK(CLK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SCK_IN(SCK_IN), .SS_N_IN(SS_N_IN), .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE),
  .MOSI_OE(MOSI_OE),
  .MISO_OE(MISO_OE), .SCK_DIR_OUT(SCK_DIR_OUT), .MOSI_DIR_OUT(MOSI_DIR_OUT), .MISO_DIR_OUT(MISO_DIR_OUT),
  .IRQ_VECTOR_ACK(IRQ_VECTOR_ACK), .IRQ_REQ(IRQ_REQ));

// file: test/sps_slave_model.sv
`timescale 1ns/10ps
module sps_slave_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic ss_n,
  input wire logic lsb,
  input wire logic [1:0] mode,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  logic [7:0] sh;
  initial miso = 1'b0;
  always @(negedge ss_n)
  begin
    sh = tx;
    miso = lsb ? sh[0] : sh[7];
  end
  // Released line shows the inverse of its last level
  always @(posedge ss_n)
    miso = ~miso;
  always @(sck)
  begin
    if (!ss_n && ((sck != mode[1]) != mode[0]))
    begin
      rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
      sh = lsb ? sh >> 1 : sh << 1;
    end
    else if (!ss_n)
      miso = lsb ? sh[0] : sh[7];
  end
endmodule : sps_slave_model

// file: test/testbench.sv
`timescale 1ns/10ps
module testbench;
  import sps_pkg::*;
  logic CLK, SYS_RST, HSEL, HWRITE, IRQ_VECTOR_ACK, SS_N_IN, ss_m, mdir, miso, sck_s, mosi_s, sdir;
  logic HREADYOUT, HRESP, SCK_OUT, SCK_OE, MOSI_OUT, MOSI_OE, MISO_OUT, MISO_OE;
  logic [31:0] HADDR, HWDATA, HRDATA, rd, r;
  logic [1:0] HTRANS, IRQ_REQ;
  logic [2:0] HSIZE;
  logic [7:0] cm, tx_m, rx_m, db;
  int num_errors, n_tests, cyc, act;
  sps_top u_sps_top (.CLK(CLK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .SCK_IN(sck_s), .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE), .MOSI_IN(mosi_s), .MOSI_OUT(MOSI_OUT), .MOSI_OE(MOSI_OE),
    .MISO_IN(miso), .MISO_OUT(MISO_OUT), .MISO_OE(MISO_OE), .SS_N_IN(SS_N_IN), .SS_DIR_OUT(sdir),
    .MOSI_DIR_OUT(1'b1), .SCK_DIR_OUT(1'b1), .MISO_DIR_OUT(mdir), .IRQ_VECTOR_ACK(IRQ_VECTOR_ACK),
    .IRQ_REQ(IRQ_REQ));
  sps_slave_model u_sps_slave_model (.sck(SCK_OUT), .mosi(MOSI_OUT), .ss_n(ss_m), .lsb(cm[5]), .mode(cm[3:2]),
    .tx(tx_m), .miso(miso), .rx(rx_m));
  ////////////////////////////////////////////////////////////
  function logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  function int divf(input logic d, input logic [1:0] c);
    return (c == 2'h3 ? 128 : 4 << (2 * c)) >> d;
  endfunction : divf
  task end_sim;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] s, input logic [31:0] e, input string n);
    n_tests++;
    if (s !== e)
    begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= SPS_HTRANS_NONSEQ;
    HADDR <= a;
    HWRITE <= w;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
    HSEL <= 1'b0;
  endtask : bus
  task rdc(input logic [31:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, e, n);
  endtask : rdc
  // External master: n bits, every clock phase four cycles long
  task slv(input logic [7:0] mb, input int n, output logic [7:0] so);
    int b;
    so = 8'h00;
    SS_N_IN <= 1'b0;
    repeat (4) @(posedge CLK);
    chk({SCK_OE, MOSI_OE, MISO_OE}, 32'(mdir), "sel");
    for (b = 0; b < n; b++)
    begin
      mosi_s <= cm[5] ? mb[b] : mb[7 - b];
      if (cm[2])
        sck_s <= !cm[3];
      repeat (4) @(posedge CLK);
      so[cm[5] ? b : 7 - b] = MISO_OUT;
      sck_s <= cm[2] ? cm[3] : !cm[3];
      repeat (4) @(posedge CLK);
      if (!cm[2])
        sck_s <= cm[3];
    end
    repeat (4) @(posedge CLK);
    SS_N_IN <= 1'b1;
    repeat (4) @(posedge CLK);
  endtask : slv
  initial
  begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      num_errors++;
      end_sim;
    end
  end
  initial
  begin
    {HSEL, HWRITE, IRQ_VECTOR_ACK, SYS_RST, SS_N_IN, ss_m, mdir} = 7'h0f;
    {HADDR, HWDATA, HTRANS, cm, tx_m, sck_s, mosi_s, sdir} = '0;
    HSIZE = 3'h2;
    r = 32'h0000_4e6b;
    repeat (5) @(posedge CLK);
    SYS_RST <= 1'b0;
    for (int a = 0; a < 12; a += 4)
      rdc(a, 32'h0000_0000, "rst");
    bus(1'b1, 32'h0000_0040, 32'hffff_ffff);
    rdc(32'h0000_0040, 32'h0000_0000, "unm");
    bus(1'b1, 32'h0000_0004, 32'h0000_00ff);
    rdc(32'h0000_0004, 32'h0000_0003, "irq");
    bus(1'b1, 32'h0000_0000, 32'h0000_0010);
    bus(1'b1, 32'h0000_000c, 32'h0000_005a);
    repeat (300) @(posedge CLK);
    rdc(32'h0000_0008, 32'h0000_0000, "dis");
    for (int i = 0; i < 8; i++)
    begin
      r = lfsr(r);
      cm = {r[7], 1'b1, i[2], 1'b1, i[1:0], r[1:0]};
      tx_m <= r[15:8];
      db = r[23:16];
      bus(1'b1, 32'h0000_0004, 32'(i % 3 + 1));
      bus(1'b1, 32'h0000_0000, {24'h00_0000, cm});
      ss_m <= 1'b0;
      bus(1'b1, 32'h0000_000c, {24'h00_0000, db});
      if (i == 3)
        bus(1'b1, 32'h0000_000c, {24'h00_0000, ~db});
      act = 0;
      while (IRQ_REQ === 2'h0)
      begin
        @(posedge CLK);
        act += int'(SCK_OUT !== cm[3]);
      end
      chk(IRQ_REQ, 32'(i % 3 + 1), "lvl");
      chk(MISO_OE, 32'h0000_0000, "oe");
      chk({SCK_OE, MOSI_OE}, 32'h0000_0003, "moe");
      if (i != 3)
        chk(act, 4 * divf(cm[7], cm[1:0]), "sck");
      if (i == 5)
      begin
        IRQ_VECTOR_ACK <= 1'b1;
        @(posedge CLK);
        IRQ_VECTOR_ACK <= 1'b0;
        @(posedge CLK);
        chk(IRQ_REQ, 32'h0000_0000, "ack");
      end
      else
        rdc(32'h0000_0008, i == 3 ? 32'h0000_00c0 : 32'h0000_0080, "st");
      rdc(32'h0000_000c, tx_m, "rx");
      chk(rx_m, db, "tx");
      rdc(32'h0000_0008, 32'h0000_0000, "clr");
      ss_m <= 1'b1;
    end
    bus(1'b1, 32'h0000_0000, 32'h0000_0050);
    sdir <= 1'b1;
    SS_N_IN <= 1'b0;
    repeat (4) @(posedge CLK);
    rdc(32'h0000_0000, 32'h0000_0050, "keep");
    sdir <= 1'b0;
    repeat (4) @(posedge CLK);
    rdc(32'h0000_0000, 32'h0000_0040, "dem");
    rdc(32'h0000_0008, 32'h0000_0080, "demf");
    SS_N_IN <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      r = lfsr(r);
      cm = {2'h1, r[5], 1'b0, i[1:0], 2'h0};
      sck_s <= cm[3];
      mdir <= r[24];
      bus(1'b1, 32'h0000_0000, {24'h00_0000, cm});
      bus(1'b1, 32'h0000_000c, {24'h00_0000, r[15:8]});
      chk(MISO_OE, 32'h0000_0000, "soe");
      if (i == 0)
      begin
        slv(r[23:16], 3, db);
        rdc(32'h0000_0008, 32'h0000_0000, "part");
      end
      slv(r[23:16], 8, db);
      chk(db, r[15:8], "miso");
      rdc(32'h0000_0008, 32'h0000_0080, "sst");
      rdc(32'h0000_000c, r[23:16], "srx");
    end
    repeat (4) @(posedge CLK);
    end_sim;
  end
endmodule : testbench
